// file: bench/ifbrr_slave_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// bus slave model returning fetch data
// ----------------------------------------------------------------------
module ifbrr_slave_model (
    input wire logic clk_in,     // core clock
    output logic [63:0] bus_out, // read data
    output logic ack_out,        // read ack
    output logic [2:0] ord_out,  // order code
    output logic busy_out,       // busy level
    output logic err_out,        // error flag
    output logic wide_out        // 1: wide slave
);
    logic [2:0] fault_ord_log = 3'h0; // order code of last errored word
    // busy starts high: traffic from before a core reset
    initial
    begin
        bus_out = 64'h0;
        ack_out = 1'b0;
        ord_out = 3'h0;
        busy_out = 1'b1;
        err_out = 1'b0;
        wide_out = 1'b0;
    end
    // one transfer, launched at a falling edge
    task automatic send(input logic wide, input logic [2:0] ord,
        input logic [63:0] d, input logic err);
        ack_out = 1'b1; // one cycle, or held for back to back
        wide_out = wide;
        ord_out = ord; // any word order
        bus_out = wide ? d : {d[31:0], d[31:0]}; // duplicated
        err_out = err; // only beside its ack
        if (err)
            fault_ord_log = ord; // kept for diagnosis
        busy_out = 1'b1; // busy while the line runs
        @(negedge clk_in);
    endtask
    // released lines show the inverse so stale values cannot match
    task automatic rel(input logic last);
        ack_out = 1'b0;
        bus_out = ~bus_out;
        ord_out = ~ord_out;
        err_out = 1'b0; // error never stands outside an ack
        wide_out = ~wide_out;
        if (last)
        begin
            busy_out = 1'b0; // cycle after the last ack
        end
        @(negedge clk_in);
    endtask
endmodule

// file: bench/ifbrr_top_tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// self-checking bench of the fetch read-return path
// ----------------------------------------------------------------------
module ifbrr_top_tb;
    logic clk = 1'b0; // core clock
    logic rst = 1'b1; // reset, high
    logic start = 1'b0, eight = 1'b0, cach = 1'b0; // line controls
    logic exv = 1'b0, rdy = 1'b1; // exec pulse, consumer ready
    logic [2:0] exi = 3'h0; // exec index
    logic [63:0] bus; // slave lines
    logic ack, busy, err, wide;
    logic [2:0] ord;
    logic allow, iv, ipair, ierr, cwr, disc, ofault, mchk;
    logic [63:0] idata;
    logic [2:0] iidx;
    logic [255:0] cline;
    logic [ifbrr_pkg::REC_W-1:0] recs[$]; // records taken
    int n_wr, n_disc, n_of, n_mc; // pulse cycle counts
    int err_total = 0;
    int checks_done = 0;
    always #2.5 clk = ~clk;
    ifbrr_slave_model ifbrr_slave_model_inst (.clk_in(clk),
        .bus_out(bus), .ack_out(ack), .ord_out(ord), .busy_out(busy),
        .err_out(err), .wide_out(wide));
    ifbrr_top ifbrr_top_inst (.MCLK_IN(clk), .SYS_RST_IN(rst),
        .IFETCH_READ_BUS_IN(bus), .IFETCH_READ_ACK_IN(ack),
        .IFETCH_TRANSFER_ORDER_IN(ord), .IFETCH_SLAVE_BUSY_IN(busy),
        .IFETCH_SLAVE_ERROR_IN(err), .IFETCH_SLAVE_WIDTH_IN(wide),
        .LINE_START_IN(start), .LINE_EIGHT_IN(eight),
        .LINE_CACHEABLE_IN(cach), .EXEC_VALID_IN(exv),
        .EXEC_INDEX_IN(exi), .INSTR_READY_IN(rdy),
        .FETCH_REQ_ALLOW_OUT(allow), .INSTR_VALID_OUT(iv),
        .INSTR_DATA_OUT(idata), .INSTR_INDEX_OUT(iidx),
        .INSTR_PAIR_OUT(ipair), .INSTR_ERROR_OUT(ierr),
        .CACHE_WRITE_OUT(cwr), .LINE_DISCARD_OUT(disc),
        .CACHE_LINE_OUT(cline), .ORDER_FAULT_OUT(ofault),
        .MACHINE_CHECK_OUT(mchk));
    // ------------------------------------------------------------------
    // monitor: stream records and pulse cycles
    // ------------------------------------------------------------------
    always @(posedge clk)
    begin
        if (iv === 1'b1 && rdy === 1'b1)
            recs.push_back({ierr, ipair, iidx, idata});
        if (cwr === 1'b1) n_wr++;
        if (disc === 1'b1) n_disc++;
        if (ofault === 1'b1) n_of++;
        if (mchk === 1'b1) n_mc++;
    end
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %0h expected %0h",
                $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (err_total == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [31:0] wv(input int i);
        return 32'h5a00_0000 + 32'(i); // marked instruction word
    endfunction
    function automatic logic [ifbrr_pkg::REC_W-1:0] rec(input logic e,
        input logic p, input logic [2:0] i, input logic [63:0] d);
        return {e, p, i, d};
    endfunction
    // clears the fill masks and the bench's own tallies
    task automatic start_line(input logic e8, input logic c);
        start = 1'b1;
        eight = e8;
        cach = c;
        recs.delete();
        {n_wr, n_disc, n_of, n_mc} = '0;
        @(negedge clk);
        start = 1'b0;
    endtask
    task automatic exec(input logic [2:0] i);
        exv = 1'b1;
        exi = i;
        @(negedge clk);
        exv = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_gate();
        repeat (4) @(negedge clk);
        check(256'(allow), 256'h0); // busy still high after reset
        ifbrr_slave_model_inst.rel(1'b1);
        check(256'(allow), 256'h1); // gate opens on busy low
    endtask
    task automatic t_wide8();
        logic [255:0] line_e;
        int k;
        int codes[4] = '{6, 0, 4, 2};
        for (int i = 0; i < 8; i++) line_e[255-32*i -: 32] = wv(i);
        start_line(1'b1, 1'b1);
        for (int j = 0; j < 4; j++)
        begin
            k = codes[j];
            ifbrr_slave_model_inst.send(1'b1, 3'(k), {wv(k), wv(k+1)}, 1'b0);
            if (j == 1) ifbrr_slave_model_inst.rel(1'b0);
        end
        ifbrr_slave_model_inst.rel(1'b1);
        repeat (4) @(negedge clk);
        check(256'(recs.size()), 256'h4); // one record per ack
        for (int j = 0; j < 4; j++)
        begin
            k = codes[j];
            check(256'(recs[j]), 256'(rec(1'b0, 1'b1, 3'(k),
                {wv(k), wv(k+1)}))); // pair by code
        end
        check(cline, line_e); // words placed by code
        check(256'(n_wr), 256'h1); // clean line cached once
        check(256'(n_disc), 256'h0); // no discard
    endtask
    task automatic t_narrow4();
        logic [127:0] line_e;
        int idx[4] = '{2, 1, 3, 0};
        logic [2:0] codes[4] = '{3'h6, 3'h1, 3'h3, 3'h4};
        for (int i = 0; i < 4; i++) line_e[127-32*i -: 32] = wv(i + 16);
        start_line(1'b0, 1'b1);
        for (int j = 0; j < 4; j++)
        begin
            // the line runs on after the error
            ifbrr_slave_model_inst.send(1'b0, codes[j],
                64'(wv(idx[j] + 16)), 1'(j == 2));
            ifbrr_slave_model_inst.rel(1'(j == 3));
        end
        repeat (4) @(negedge clk);
        check(256'(recs.size()), 256'h4); // one word per ack
        for (int j = 0; j < 4; j++)
            check(256'(recs[j]), 256'(rec(1'(j == 2), 1'b0, 3'(idx[j]),
                {2{wv(idx[j] + 16)}}))); // low code bits
        check(256'(cline[255:128]), 256'(line_e)); // fill words
        check(256'(n_disc), 256'h1); // errored line not cached
        check(256'(n_wr), 256'h0); // no cache write
        check(256'(ifbrr_slave_model_inst.fault_ord_log), 256'h3);
        exec(3'h1);
        check(256'(n_mc), 256'h0); // clean word executes quietly
        exec(3'h3);
        check(256'(n_mc), 256'h1); // errored word traps once
    endtask
    task automatic t_odd();
        start_line(1'b1, 1'b1);
        ifbrr_slave_model_inst.send(1'b1, 3'h3, {wv(2), wv(3)}, 1'b0);
        ifbrr_slave_model_inst.rel(1'b1);
        repeat (4) @(negedge clk);
        check(256'(n_of), 256'h1); // odd code flagged once
        check(256'(recs.size()), 256'h0); // nothing streamed
        // narrow slave on an eight-word line uses all three code bits
        ifbrr_slave_model_inst.send(1'b0, 3'h5, 64'(wv(37)), 1'b0);
        ifbrr_slave_model_inst.rel(1'b1);
        repeat (4) @(negedge clk);
        check(256'(recs[0]), 256'(rec(1'b0, 1'b0, 3'h5,
            {2{wv(37)}}))); // top code bit kept
        check(256'(cline[95:64]), 256'(wv(37))); // word 5 slot
    endtask
    // stalled consumer: two records kept, third dropped by choice
    task automatic t_stall();
        start_line(1'b0, 1'b0);
        rdy = 1'b0;
        ifbrr_slave_model_inst.send(1'b1, 3'h0, {wv(0), wv(1)}, 1'b0);
        ifbrr_slave_model_inst.send(1'b1, 3'h2, {wv(2), wv(3)}, 1'b0);
        ifbrr_slave_model_inst.send(1'b1, 3'h0, {wv(4), wv(5)}, 1'b0);
        ifbrr_slave_model_inst.rel(1'b1);
        repeat (3) @(negedge clk);
        check(256'(allow), 256'h0); // full buffer closes gate
        check(256'(iv), 256'h1); // held until taken
        rdy = 1'b1;
        repeat (4) @(negedge clk);
        check(256'(recs.size()), 256'h2); // both kept records drain
        check(256'(recs[0]), 256'(rec(1'b0, 1'b1, 3'h0,
            {wv(0), wv(1)}))); // first entry intact
        check(256'(recs[1]), 256'(rec(1'b0, 1'b1, 3'h2,
            {wv(2), wv(3)}))); // second entry intact
        check(256'(n_wr + n_disc), 256'h0); // uncached line
        check(256'(allow), 256'h1); // gate reopens
    endtask
    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        t_gate();
        t_wide8();
        t_narrow4();
        t_odd();
        t_stall();
        complete_run();
    end
    initial
    begin
        #20000;
        err_total++;
        complete_run();
    end
endmodule

// file: rtl/ifbrr_fifo.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// small fifo, registered storage, honest full and empty
// ----------------------------------------------------------------------
module ifbrr_fifo #(
    parameter int W = ifbrr_pkg::REC_W,
    parameter int DEPTH = ifbrr_pkg::BUF_DEPTH
)(
    input wire logic clk_in,           // core clock
    input wire logic rst_in,           // async reset, high
    ifbrr_stream_if.snk fill,          // filling side
    ifbrr_stream_if.src drain          // draining side
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [W-1:0] mem_q [DEPTH];       // storage slots
    logic [PW-1:0] wr_q, wr_d;         // write pointer
    logic [PW-1:0] rd_q, rd_d;         // read pointer
    logic [PW:0] cnt_q, cnt_d;         // occupancy
    logic push, pop;                   // accepted moves

    assign fill.ready = (cnt_q != FULL_CNT);
    assign drain.valid = (cnt_q != '0);
    assign drain.data = mem_q[rd_q];

    // ----------------------------------------------------------------
    // pointer and count update
    // ----------------------------------------------------------------
    always_comb
    begin
        push = fill.valid && fill.ready;
        pop = drain.valid && drain.ready;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push)
            wr_d = (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
        if (pop)
            rd_d = (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
        // simultaneous push and pop keeps the count
        if (push && !pop)
            cnt_d = cnt_q + 1'b1;
        else if (pop && !push)
            cnt_d = cnt_q - 1'b1;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage needs no reset: never read while empty
    always_ff @(posedge clk_in)
    begin
        if (push)
            mem_q[wr_q] <= fill.data;
    end
endmodule

// file: rtl/ifbrr_pkg.sv
// ----------------------------------------------------------------------
// shared constants of the fetch read-return path
// ----------------------------------------------------------------------
package ifbrr_pkg;
    localparam int BUS_W = 64;          // read bus width
    localparam int WORD_W = 32;         // one instruction
    localparam int ORD_W = 3;           // transfer order code width
    localparam int LINE_WORDS = 8;      // largest line, in words
    localparam int IDX_W = 3;           // word index within a line
    localparam int REC_W = BUS_W + IDX_W + 2; // err, pair, idx, data
    localparam int BUF_DEPTH = 2;       // entries in the stream buffer
    // field positions inside a stream record
    localparam int REC_ERR_BIT = REC_W - 1;
    localparam int REC_PAIR_BIT = REC_W - 2;
    localparam int REC_IDX_LSB = BUS_W;
    // order code: bit 0 is the odd-word bit, illegal for wide slaves
    localparam int ORD_ODD_BIT = 0;
    // line masks for four-word and eight-word lines
    localparam logic [7:0] MASK_LINE4 = 8'h0f;
    localparam logic [7:0] MASK_LINE8 = 8'hff;
    localparam logic [7:0] MASK_NONE = 8'h00;
    // request gating after reset, gray along wait -> open
    typedef enum logic [1:0]
    {
        IFBRR_GATE_WAIT = 2'h0,
        IFBRR_GATE_OPEN = 2'h1
    } ifbrr_gate_t;
endpackage

// file: rtl/ifbrr_stream_if.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// valid/ready stream between the fill logic and its buffer
// ----------------------------------------------------------------------
interface ifbrr_stream_if #(parameter int W = ifbrr_pkg::REC_W);
    logic valid;        // record offered
    logic ready;        // record can be taken
    logic [W-1:0] data; // record payload
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// file: rtl/ifbrr_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - read bus valid only with read ack
// - narrow slave: pick half by order code
// - wide slave: capture both words same cycle
// - order code names word, any order
// - narrow index: low two or three bits
// - wide code 2k: words 2k, 2k+1; odd invalid
// - no request until busy first seen low
// - errored words fill buffer, line not cached
// - machine check only when errored word executes
// - sample bus, order, error on ack
module ifbrr_top (
    input wire logic MCLK_IN,                // core clock, 200 MHz
    input wire logic SYS_RST_IN,             // async reset, high
    input wire logic [63:0] IFETCH_READ_BUS_IN, // read data bus
    input wire logic IFETCH_READ_ACK_IN,     // read data ack
    input wire logic [2:0] IFETCH_TRANSFER_ORDER_IN, // order code
    input wire logic IFETCH_SLAVE_BUSY_IN,   // slave busy
    input wire logic IFETCH_SLAVE_ERROR_IN,  // transfer error
    input wire logic IFETCH_SLAVE_WIDTH_IN,  // 1: wide slave
    input wire logic LINE_START_IN,          // new line, clear fill
    input wire logic LINE_EIGHT_IN,          // 1: eight-word line
    input wire logic LINE_CACHEABLE_IN,      // line is cacheable
    input wire logic EXEC_VALID_IN,          // word about to execute
    input wire logic [2:0] EXEC_INDEX_IN,    // its fill index
    input wire logic INSTR_READY_IN,         // fetch unit takes
    output logic FETCH_REQ_ALLOW_OUT,        // new request allowed
    output logic INSTR_VALID_OUT,            // bypass record valid
    output logic [63:0] INSTR_DATA_OUT,      // bypass data
    output logic [2:0] INSTR_INDEX_OUT,      // first word index
    output logic INSTR_PAIR_OUT,             // two words carried
    output logic INSTR_ERROR_OUT,            // carried with error
    output logic CACHE_WRITE_OUT,            // write line to cache
    output logic LINE_DISCARD_OUT,           // line dropped, error
    output logic [255:0] CACHE_LINE_OUT,     // fill buffer words
    output logic ORDER_FAULT_OUT,            // invalid order code
    output logic MACHINE_CHECK_OUT           // machine check
);
    // ------------------------------------------------------------------
    // sample stage
    // ------------------------------------------------------------------
    logic smp_vld_q, smp_vld_d;              // sampled transfer
    logic [63:0] smp_bus_q, smp_bus_d;       // sampled data
    logic [2:0] smp_ord_q, smp_ord_d;        // sampled order
    logic smp_err_q, smp_err_d;              // sampled error
    logic smp_wide_q, smp_wide_d;            // sampled width

    // contents ignored outside ack cycles
    always_comb
    begin
        smp_vld_d = IFETCH_READ_ACK_IN;
        smp_bus_d = smp_bus_q;
        smp_ord_d = smp_ord_q;
        smp_err_d = smp_err_q;
        smp_wide_d = smp_wide_q;
        if (IFETCH_READ_ACK_IN)
        begin
            smp_bus_d = IFETCH_READ_BUS_IN;
            smp_ord_d = IFETCH_TRANSFER_ORDER_IN;
            smp_err_d = IFETCH_SLAVE_ERROR_IN;
            smp_wide_d = IFETCH_SLAVE_WIDTH_IN;
        end
    end

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            smp_vld_q <= 1'b0;
            smp_bus_q <= '0;
            smp_ord_q <= '0;
            smp_err_q <= 1'b0;
            smp_wide_q <= 1'b0;
        end
        else
        begin
            smp_vld_q <= smp_vld_d;
            smp_bus_q <= smp_bus_d;
            smp_ord_q <= smp_ord_d;
            smp_err_q <= smp_err_d;
            smp_wide_q <= smp_wide_d;
        end
    end

    // ------------------------------------------------------------------
    // order decode
    // ------------------------------------------------------------------
    // word index named by an order code
    function automatic logic [2:0] ifbrr_index(input logic [2:0] ord,
        input logic wide, input logic eight);
        logic [2:0] idx;
        idx = eight ? ord : {1'b0, ord[1:0]};    // top bit don't-care
        if (wide)
            idx[ifbrr_pkg::ORD_ODD_BIT] = 1'b0;  // even word of pair
        return idx;
    endfunction

    // narrow slave: odd word from low half, even from high
    function automatic logic [31:0] ifbrr_half(input logic [63:0] bus,
        input logic [2:0] ord);
        return ord[ifbrr_pkg::ORD_ODD_BIT] ? bus[31:0] : bus[63:32];
    endfunction

    // ------------------------------------------------------------------
    // fill buffer and line completion
    // ------------------------------------------------------------------
    logic [31:0] words_q [ifbrr_pkg::LINE_WORDS];  // fill words
    logic [31:0] words_d [ifbrr_pkg::LINE_WORDS];
    logic [7:0] vmask_q, vmask_d;            // words present
    logic [7:0] emask_q, emask_d;            // words with error
    logic [7:0] need;                        // words in this line
    logic [2:0] wr_idx;                      // decoded index
    logic bad_ord;                           // odd code, wide slave
    logic wr_en;                             // legal transfer
    logic done_d;                            // line just completed
    logic cwr_q, cwr_d;                      // cache write pulse
    logic disc_q, disc_d;                    // discard pulse
    logic ofault_q;                          // order fault pulse

    always_comb
    begin
        need = LINE_EIGHT_IN ? ifbrr_pkg::MASK_LINE8
                             : ifbrr_pkg::MASK_LINE4;
        wr_idx = ifbrr_index(smp_ord_q, smp_wide_q, LINE_EIGHT_IN);
        // slave broke the odd-bit rule: drop and flag it
        bad_ord = smp_vld_q && smp_wide_q
                  && smp_ord_q[ifbrr_pkg::ORD_ODD_BIT];
        wr_en = smp_vld_q && !bad_ord;
        words_d = words_q;
        vmask_d = vmask_q;
        emask_d = emask_q;
        // new line clears masks; a write in the same cycle survives
        if (LINE_START_IN)
        begin
            vmask_d = ifbrr_pkg::MASK_NONE;
            emask_d = ifbrr_pkg::MASK_NONE;
        end
        if (wr_en && smp_wide_q)
        begin
            // both words in the one cycle
            words_d[wr_idx] = smp_bus_q[63:32];
            words_d[wr_idx + 3'h1] = smp_bus_q[31:0];
            vmask_d[wr_idx] = 1'b1;
            vmask_d[wr_idx + 3'h1] = 1'b1;
            emask_d[wr_idx] = emask_d[wr_idx] | smp_err_q;
            emask_d[wr_idx + 3'h1] = emask_d[wr_idx + 3'h1] | smp_err_q;
        end
        else if (wr_en)
        begin
            // one word from the half the code selects
            words_d[wr_idx] = ifbrr_half(smp_bus_q, smp_ord_q);
            vmask_d[wr_idx] = 1'b1;
            emask_d[wr_idx] = emask_d[wr_idx] | smp_err_q;
        end
        // errored words still land in the fill buffer
        done_d = wr_en && ((vmask_d & need) == need);
        cwr_d = done_d && LINE_CACHEABLE_IN && ((emask_d & need) == '0);
        disc_d = done_d && LINE_CACHEABLE_IN && ((emask_d & need) != '0);
    end

    // words hold their value; only the masks and pulses are reset
    always_ff @(posedge MCLK_IN)
    begin
        words_q <= words_d;
    end

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            vmask_q <= ifbrr_pkg::MASK_NONE;
            emask_q <= ifbrr_pkg::MASK_NONE;
            cwr_q <= 1'b0;
            disc_q <= 1'b0;
            ofault_q <= 1'b0;
        end
        else
        begin
            vmask_q <= vmask_d;
            emask_q <= emask_d;
            cwr_q <= cwr_d;      // cache write only if no error
            disc_q <= disc_d;
            ofault_q <= bad_ord;
        end
    end

    // line as a flat vector, word 0 in the top slot
    genvar g;
    generate
        for (g = 0; g < ifbrr_pkg::LINE_WORDS; g++)
        begin : g_line
            assign CACHE_LINE_OUT[255 - 32*g -: 32] = words_q[g];
        end
    endgenerate

    assign CACHE_WRITE_OUT = cwr_q;
    assign LINE_DISCARD_OUT = disc_q;
    assign ORDER_FAULT_OUT = ofault_q;

    // ------------------------------------------------------------------
    // machine check on execution of an errored word
    // ------------------------------------------------------------------
    logic mchk_q, mchk_d;                    // machine check pulse

    // error alone raises nothing; only execution does
    always_comb
    begin
        mchk_d = EXEC_VALID_IN && vmask_q[EXEC_INDEX_IN]
                 && emask_q[EXEC_INDEX_IN];
    end

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            mchk_q <= 1'b0;
        else
            mchk_q <= mchk_d;
    end

    assign MACHINE_CHECK_OUT = mchk_q;

    // ------------------------------------------------------------------
    // bypass stream through the two-entry buffer
    // ------------------------------------------------------------------
    ifbrr_stream_if #(.W(ifbrr_pkg::REC_W)) push_if ();
    ifbrr_stream_if #(.W(ifbrr_pkg::REC_W)) pop_if ();

    // slave cannot be stalled, so a full buffer closes the request gate
    assign push_if.valid = wr_en;
    assign push_if.data = {smp_err_q, smp_wide_q, wr_idx,
                           smp_wide_q ? smp_bus_q
                                      : {2{ifbrr_half(smp_bus_q,
                                                      smp_ord_q)}}};
    assign pop_if.ready = INSTR_READY_IN;

    ifbrr_fifo #(.W(ifbrr_pkg::REC_W), .DEPTH(ifbrr_pkg::BUF_DEPTH))
        u_buf (
        .clk_in (MCLK_IN),
        .rst_in (SYS_RST_IN),
        .fill (push_if),
        .drain (pop_if)
    );

    assign INSTR_VALID_OUT = pop_if.valid;
    assign INSTR_DATA_OUT = pop_if.data[ifbrr_pkg::BUS_W-1:0];
    assign INSTR_INDEX_OUT = pop_if.data[ifbrr_pkg::REC_IDX_LSB +: 3];
    assign INSTR_PAIR_OUT = pop_if.data[ifbrr_pkg::REC_PAIR_BIT];
    assign INSTR_ERROR_OUT = pop_if.data[ifbrr_pkg::REC_ERR_BIT];

    // ------------------------------------------------------------------
    // post-reset request gate
    // ------------------------------------------------------------------
    ifbrr_pkg::ifbrr_gate_t gate_q, gate_d;  // gate state

    // gate opens on the first sampled low busy
    always_comb
    begin
        case (gate_q)
            ifbrr_pkg::IFBRR_GATE_WAIT:
                gate_d = IFETCH_SLAVE_BUSY_IN ? ifbrr_pkg::IFBRR_GATE_WAIT
                                              : ifbrr_pkg::IFBRR_GATE_OPEN;
            ifbrr_pkg::IFBRR_GATE_OPEN:
                gate_d = ifbrr_pkg::IFBRR_GATE_OPEN;
            default:
                gate_d = ifbrr_pkg::IFBRR_GATE_WAIT;
        endcase
    end

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            gate_q <= ifbrr_pkg::IFBRR_GATE_WAIT;
        else
            gate_q <= gate_d;
    end

    assign FETCH_REQ_ALLOW_OUT = (gate_q == ifbrr_pkg::IFBRR_GATE_OPEN)
                                 && push_if.ready;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    sequence s_wide_ack;
        IFETCH_READ_ACK_IN && IFETCH_SLAVE_WIDTH_IN
        && !IFETCH_TRANSFER_ORDER_IN[0];
    endsequence

    chk_gate_closed: assert property (
        gate_q == ifbrr_pkg::IFBRR_GATE_WAIT |-> !FETCH_REQ_ALLOW_OUT)
        else $error("request allowed before busy seen low");
    chk_gate_opens: assert property (
        gate_q == ifbrr_pkg::IFBRR_GATE_WAIT && !IFETCH_SLAVE_BUSY_IN
        |=> gate_q == ifbrr_pkg::IFBRR_GATE_OPEN)
        else $error("gate did not open on low busy");
    chk_sample_ack: assert property (
        IFETCH_READ_ACK_IN |=> smp_vld_q
        && smp_bus_q == $past(IFETCH_READ_BUS_IN))
        else $error("acked data not sampled");
    chk_idle_ignored: assert property (
        !IFETCH_READ_ACK_IN |=> !smp_vld_q && $stable(smp_bus_q))
        else $error("bus taken without ack");
    chk_wide_pair: assert property (
        s_wide_ack ##1 1'b1 |=>
        words_q[$past(IFETCH_TRANSFER_ORDER_IN, 2)
                & {$past(LINE_EIGHT_IN), 2'b10}]
           == $past(IFETCH_READ_BUS_IN[63:32], 2)
        && words_q[($past(IFETCH_TRANSFER_ORDER_IN, 2)
                    & {$past(LINE_EIGHT_IN), 2'b10}) | 3'h1]
           == $past(IFETCH_READ_BUS_IN[31:0], 2))
        else $error("wide transfer not stored as pair");
    chk_narrow_half: assert property (
        IFETCH_READ_ACK_IN && !IFETCH_SLAVE_WIDTH_IN
        |=> ##1 words_q[$past(IFETCH_TRANSFER_ORDER_IN, 2)
                        & {$past(LINE_EIGHT_IN), 2'b11}] ==
        ($past(IFETCH_TRANSFER_ORDER_IN[0], 2)
         ? $past(IFETCH_READ_BUS_IN[31:0], 2)
         : $past(IFETCH_READ_BUS_IN[63:32], 2)))
        else $error("narrow word from wrong half");
    chk_bad_order: assert property (
        IFETCH_READ_ACK_IN && IFETCH_SLAVE_WIDTH_IN
        && IFETCH_TRANSFER_ORDER_IN[0] |-> ##2 ORDER_FAULT_OUT)
        else $error("odd wide order not flagged");
    chk_err_no_cache: assert property (
        CACHE_WRITE_OUT |-> !LINE_DISCARD_OUT && (emask_q & need) == '0)
        else $error("errored line written to cache");
    chk_mchk_cause: assert property (
        MACHINE_CHECK_OUT |-> $past(EXEC_VALID_IN)
        && $past(emask_q[EXEC_INDEX_IN]))
        else $error("machine check without errored execution");
endmodule
